// ---- ana_cfg.svh ----
// constants of the auto-negotiation advertisement register block
`ifndef ANA_CFG_SVH
`define ANA_CFG_SVH
`define ANA_ADDR_W      8
`define ANA_IDX_LSB     2
`define ANA_IDX_W       6
`define ANA_IDX_CTRL    6'h00
`define ANA_IDX_ADV     6'h04
`define ANA_BIT_RESTART 9
`define ANA_BIT_100F    8
`define ANA_BIT_100H    7
`define ANA_BIT_10F     6
`define ANA_BIT_10H     5
`define ANA_ABIL_LSB    5
`define ANA_SEL_HI      4
`define ANA_SEL_VALUE   5'h01
`define ANA_ABIL_RST    4'hF
`define ANA_UPPER_ZERO  7'h00
`define ANA_HI_ZERO     16'h0000
`define ANA_RESP_OKAY   2'h0
`define ANA_RESP_SLVERR 2'h2
`endif

// ---- ana_pkg.sv ----
// types of the auto-negotiation advertisement register block
`include "ana_cfg.svh"
package ana_pkg;
  typedef struct packed {
    logic                   awvalid;
    logic [`ANA_ADDR_W-1:0] awaddr;
    logic [2:0]             awprot;
    logic                   wvalid;
    logic [31:0]            wdata;
    logic [3:0]             wstrb;
    logic                   bready;
    logic                   arvalid;
    logic [`ANA_ADDR_W-1:0] araddr;
    logic [2:0]             arprot;
    logic                   rready;
  } ana_axi_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } ana_axi_rsp_s;

  typedef enum logic [1:0] {
    ANA_SEL_NONE = 2'b00,
    ANA_SEL_CTRL = 2'b01,
    ANA_SEL_ADV  = 2'b10
  } ana_sel_e;

  typedef struct packed {
    logic                   aw_have;
    logic [`ANA_ADDR_W-1:0] aw_addr;
    logic                   w_have;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [3:0]             abil;
    logic                   restart;
  } ana_state_s;
endpackage

// ---- ana_advertise.sv ----
// auto-negotiation advertisement register bank behind an AXI4-Lite slave
// Behaviour
// - 100TX full-duplex bit 8, read/write, resets 1
// - bit 8 set advertises 100TX full duplex
// - 10T full-duplex bit 6, read/write, resets 1
// - 10T half-duplex bit 5, read/write, resets 1
// - selector bits 4:0 read-only, fixed 0x01
`include "ana_cfg.svh"
module ana_advertise
  import ana_pkg::*;
(
  input  wire logic         aclk,                // 20 MHz bus clock
  input  wire logic         aresetn,             // synchronous reset, active low
  input  wire ana_axi_req_s s_axi_req,           // AXI4-Lite master to slave
  output ana_axi_rsp_s      s_axi_rsp,           // AXI4-Lite slave to master
  output logic [15:0]       autoneg_advertisement, // base page word to the negotiation engine
  output logic              restart_negotiation, // restart request, held until acknowledged
  input  wire logic         restart_ack          // engine took the restart, same clock
);

  ana_state_s st_q;
  ana_state_s st_d;

  function automatic ana_sel_e decode(input logic [`ANA_ADDR_W-1:0] addr);
    logic [`ANA_IDX_W-1:0] idx;
    idx = addr[`ANA_ADDR_W-1:`ANA_IDX_LSB];
    if (idx == `ANA_IDX_CTRL) begin
      decode = ANA_SEL_CTRL;
    end else if (idx == `ANA_IDX_ADV) begin
      decode = ANA_SEL_ADV;
    end else begin
      decode = ANA_SEL_NONE;
    end
  endfunction

  logic     aw_hs;
  logic     w_hs;
  logic     ar_hs;
  logic     commit;
  ana_sel_e wsel;
  ana_sel_e rsel;
  logic [15:0] ctrl_word;

  // the bit fields sit in place; upper bits of this slice are outside the block and read zero
  assign autoneg_advertisement = {`ANA_UPPER_ZERO, st_q.abil, `ANA_SEL_VALUE};
  assign restart_negotiation   = st_q.restart;
  assign ctrl_word             = 16'(st_q.restart) << `ANA_BIT_RESTART;

  // one write and one read in flight; address and data may arrive in either order
  assign s_axi_rsp.awready = ~st_q.aw_have & ~st_q.bvalid;
  assign s_axi_rsp.wready  = ~st_q.w_have & ~st_q.bvalid;
  assign s_axi_rsp.arready = ~st_q.rvalid;
  assign s_axi_rsp.bvalid  = st_q.bvalid;
  assign s_axi_rsp.bresp   = st_q.bresp;
  assign s_axi_rsp.rvalid  = st_q.rvalid;
  assign s_axi_rsp.rdata   = st_q.rdata;
  assign s_axi_rsp.rresp   = st_q.rresp;

  assign aw_hs  = s_axi_req.awvalid & s_axi_rsp.awready;
  assign w_hs   = s_axi_req.wvalid & s_axi_rsp.wready;
  assign ar_hs  = s_axi_req.arvalid & s_axi_rsp.arready;
  assign commit = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
  assign wsel   = decode(st_q.aw_addr);
  assign rsel   = decode(s_axi_req.araddr);

  always_comb begin
    st_d = st_q;
    if (aw_hs) begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = s_axi_req.awaddr;
    end
    if (w_hs) begin
      st_d.w_have = 1'b1;
      st_d.w_data = s_axi_req.wdata;
      st_d.w_strb = s_axi_req.wstrb;
    end
    // engine ack clears the request, but a new software restart in the same cycle wins
    if (restart_ack) begin
      st_d.restart = 1'b0;
    end
    if (commit) begin
      st_d.aw_have = 1'b0;
      st_d.w_have  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = `ANA_RESP_OKAY;
      case (wsel)
        ANA_SEL_ADV: begin
          // bit 8 rides byte lane 1, bits 7:5 byte lane 0; selector ignores writes
          if (st_q.w_strb[1]) begin
            st_d.abil[3] = st_q.w_data[`ANA_BIT_100F];
          end
          if (st_q.w_strb[0]) begin
            st_d.abil[2] = st_q.w_data[`ANA_BIT_100H];
            st_d.abil[1] = st_q.w_data[`ANA_BIT_10F];
            st_d.abil[0] = st_q.w_data[`ANA_BIT_10H];
          end
        end
        ANA_SEL_CTRL: begin
          if (st_q.w_strb[1] && st_q.w_data[`ANA_BIT_RESTART]) begin
            st_d.restart = 1'b1;
          end
        end
        default: begin
          st_d.bresp = `ANA_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && s_axi_req.bready) begin
      st_d.bvalid = 1'b0;
    end
    if (st_q.rvalid && s_axi_req.rready) begin
      st_d.rvalid = 1'b0;
    end
    if (ar_hs) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = `ANA_RESP_OKAY;
      case (rsel)
        ANA_SEL_ADV: begin
          st_d.rdata = {`ANA_HI_ZERO, autoneg_advertisement};
        end
        ANA_SEL_CTRL: begin
          st_d.rdata = {`ANA_HI_ZERO, ctrl_word};
        end
        default: begin
          st_d.rdata = 32'h00000000;
          st_d.rresp = `ANA_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q         <= '0;
      st_q.abil    <= `ANA_ABIL_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // checks

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic adv_wr;
  logic adv_wr_hi;
  logic restart_wr;
  assign adv_wr     = commit && (wsel == ANA_SEL_ADV);
  assign adv_wr_hi  = adv_wr && st_q.w_strb[1];
  assign restart_wr = commit && (wsel == ANA_SEL_CTRL) && st_q.w_strb[1] && st_q.w_data[`ANA_BIT_RESTART];

  sequence s_adv_write_lane1;
    adv_wr && st_q.w_strb[1];
  endsequence

  sequence s_adv_write_lane0;
    adv_wr && st_q.w_strb[0];
  endsequence

  sequence s_restart_write;
    restart_wr;
  endsequence

  a_reset_abilities: assert property ($rose(aresetn) |-> autoneg_advertisement[8:5] == `ANA_ABIL_RST)
    else $error("ability bits not all set after reset");

  a_write_100f: assert property (s_adv_write_lane1 |=> autoneg_advertisement[8] == $past(st_q.w_data[8]))
    else $error("100TX full-duplex bit did not take written value");

  // the advertised 100TX full-duplex bit moves only through a lane-1 write of the advertisement
  a_advertise_100f: assert property ($changed(autoneg_advertisement[`ANA_BIT_100F]) |-> $past(adv_wr_hi))
    else $error("advertised 100TX full-duplex bit changed without a write");

  a_write_100h: assert property (s_adv_write_lane0 |=> autoneg_advertisement[7] == $past(st_q.w_data[7]))
    else $error("100TX half-duplex bit did not take written value");

  a_write_10f: assert property (s_adv_write_lane0 |=> autoneg_advertisement[6] == $past(st_q.w_data[6]))
    else $error("10T full-duplex bit did not take written value");

  a_write_10h: assert property (s_adv_write_lane0 |=> autoneg_advertisement[5] == $past(st_q.w_data[5]))
    else $error("10T half-duplex bit did not take written value");

  a_abil_stable: assert property (!adv_wr |=> $stable(autoneg_advertisement))
    else $error("ability bits changed without a write");

  a_selector_fixed: assert property (autoneg_advertisement[4:0] == `ANA_SEL_VALUE)
    else $error("selector field is not 0x01");

  a_read_adv: assert property (ar_hs && rsel == ANA_SEL_ADV |=>
                               s_axi_rsp.rvalid && s_axi_rsp.rdata[4:0] == `ANA_SEL_VALUE
                               && s_axi_rsp.rdata[15:0] == $past(autoneg_advertisement))
    else $error("read of advertisement returned wrong data");

  a_restart_hold: assert property (restart_negotiation && !restart_ack |=> restart_negotiation)
    else $error("restart request dropped before acknowledge");

  a_restart_set: assert property (s_restart_write |=> restart_negotiation)
    else $error("restart request not raised by a control write");

  // a software restart in the same cycle as the engine's take keeps the request up
  a_restart_clear: assert property (restart_ack && !restart_wr |=> !restart_negotiation)
    else $error("restart request not cleared by acknowledge");

  a_write_resp: assert property (commit |=> s_axi_rsp.bvalid)
    else $error("write response missing after commit");

  a_write_unmapped: assert property (commit && wsel == ANA_SEL_NONE |=>
                                     s_axi_rsp.bresp == `ANA_RESP_SLVERR && $stable(st_q.abil))
    else $error("write to an unmapped word not refused");

  a_read_unmapped: assert property (ar_hs && rsel == ANA_SEL_NONE |=>
                                    s_axi_rsp.rresp == `ANA_RESP_SLVERR && s_axi_rsp.rdata == 32'h00000000)
    else $error("read of an unmapped word not refused");

  a_bvalid_clear: assert property (s_axi_rsp.bvalid && s_axi_req.bready |=> !s_axi_rsp.bvalid)
    else $error("write response not released after bready");

  a_rvalid_clear: assert property (s_axi_rsp.rvalid && s_axi_req.rready |=> !s_axi_rsp.rvalid)
    else $error("read response not released after rready");

  // readies must be up at once after reset so the first request is not stalled
  a_ready_reset: assert property ($rose(aresetn) |-> s_axi_rsp.awready && s_axi_rsp.wready && s_axi_rsp.arready)
    else $error("bus not ready after reset");

endmodule

// ---- ana_engine_model.sv ----
// behavioural negotiation engine that takes restart requests after a delay
module ana_engine_model #(
  parameter int ACK_DELAY = 20
) (
  input  wire logic        aclk,                // bus clock
  input  wire logic        aresetn,             // synchronous reset, active low
  input  wire logic [15:0] advertisement,       // base page word
  input  wire logic        restart_negotiation, // restart request
  output logic             restart_ack,         // one-cycle take
  output logic [15:0]      page_sent            // word sent at the last restart
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // a slow engine keeps the request visible long enough for software to read it back
  always @(posedge aclk) begin
    restart_ack <= 1'b0;
    if (!aresetn) begin
      cnt <= 0;
      page_sent <= 16'h0000;
    end else if (restart_negotiation && !restart_ack) begin
      if (cnt == ACK_DELAY) begin
        restart_ack <= 1'b1;
        page_sent <= advertisement;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule

// ---- test_autoneg_ability_advertise.sv ----
// self-checking bench of the advertisement register bank
`include "ana_cfg.svh"
module test_autoneg_ability_advertise import ana_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  ana_axi_req_s req = '0;
  ana_axi_rsp_s rsp;
  logic [15:0]  adv, page;
  logic         restart, ack;
  int           fail_count = 0;
  int           checks = 0;
  logic [31:0]  seed = 32'hA172ED37;
  logic [3:0]   m_abil = 4'hF;
  logic [31:0]  rd, wd;
  logic [1:0]   rs;

  always #25 aclk = ~aclk;

  ana_advertise u_ana_advertise (.aclk(aclk), .aresetn(aresetn), .s_axi_req(req), .s_axi_rsp(rsp),
    .autoneg_advertisement(adv), .restart_negotiation(restart), .restart_ack(ack));
  ana_engine_model #(.ACK_DELAY(20)) u_ana_engine_model (.aclk(aclk), .aresetn(aresetn), .advertisement(adv),
    .restart_negotiation(restart), .restart_ack(ack), .page_sent(page));

  function automatic logic [31:0] xs(logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // handshakes are judged at the falling edge so the rising edge never races the design
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s, output logic [1:0] r);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr  <= a;
    req.wvalid  <= 1'b1;
    req.wdata   <= d;
    req.wstrb   <= s;
    req.bready  <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa & rsp.awready;
      tw = pw & rsp.wready;
      @(posedge aclk);
      if (ta) begin
        req.awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (tw) begin
        req.wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do @(negedge aclk); while (rsp.bvalid !== 1'b1);
    r = rsp.bresp;
    @(posedge aclk);
    req.bready <= 1'b0;
  endtask

  task automatic rdr(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr  <= a;
    req.rready  <= 1'b1;
    do @(negedge aclk); while (rsp.arready !== 1'b1);
    @(posedge aclk);
    req.arvalid <= 1'b0;
    do @(negedge aclk); while (rsp.rvalid !== 1'b1);
    d = rsp.rdata;
    r = rsp.rresp;
    @(posedge aclk);
    req.rready <= 1'b0;
  endtask

  initial begin
    repeat (4000) @(posedge aclk);
    fail_count++;
    test_done();
  end

  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rdr(8'h10, rd, rs);
    check("adv reset", rd, 32'h000001E1);
    check("adv reset resp", {30'h0, rs}, {30'h0, `ANA_RESP_OKAY});
    for (int i = 0; i < 10; i++) begin
      seed = xs(seed);
      wd = seed;
      wr(8'h10, wd, seed[31:28], rs);
      check("wr resp", {30'h0, rs}, {30'h0, `ANA_RESP_OKAY});
      if (seed[29]) m_abil[3] = wd[8];
      if (seed[28]) m_abil[2:0] = wd[7:5];
      rdr(8'h10, rd, rs);
      check("adv read", rd, {16'h0, 7'h00, m_abil, 5'h01});
      check("adv read resp", {30'h0, rs}, {30'h0, `ANA_RESP_OKAY});
      check("adv port", {16'h0, adv}, {16'h0, 7'h00, m_abil, 5'h01});
    end
    // drop 100TX full keeping every other bit, then ask for a new negotiation
    rdr(8'h10, rd, rs);
    wr(8'h10, rd & ~32'h00000100, 4'hF, rs);
    m_abil[3] = 1'b0;
    wr(8'h00, 32'h00000200, 4'h2, rs);
    check("restart", {31'h0, restart}, 32'h1);
    rdr(8'h00, rd, rs);
    check("ctrl read", rd, 32'h00000200);
    for (int i = 0; i < 100 && restart === 1'b1; i++) @(posedge aclk);
    rdr(8'h00, rd, rs);
    check("ctrl clear", rd, 32'h0);
    check("page sent", {16'h0, page}, {16'h0, 7'h00, m_abil, 5'h01});
    wr(8'h08, 32'hFFFFFFFF, 4'hF, rs);
    check("unmapped wr", {30'h0, rs}, {30'h0, `ANA_RESP_SLVERR});
    rdr(8'h08, rd, rs);
    check("unmapped rd", rd, 32'h0);
    check("unmapped rresp", {30'h0, rs}, {30'h0, `ANA_RESP_SLVERR});
    test_done();
  end
endmodule
